//--- design/pps_pkg.sv
// Purpose: constants and carriers for the port protection setup registers
// Assumes: byte-wide registers reached over an internal register port
// Notes:   offsets are the device's own register addresses
`default_nettype none
package pps_pkg;
   // ***********************************************************
   // register offsets
   // ***********************************************************
   localparam logic [7:0] PPS_OFF_RETRY  = 8'h85;
   localparam logic [7:0] PPS_OFF_GEN    = 8'h86;
   localparam logic [7:0] PPS_OFF_INUV   = 8'h87;
   localparam logic [7:0] PPS_OFF_CABLE  = 8'h88;
   localparam logic [7:0] PPS_OFF_WINDOW = 8'h89;
   localparam int         PPS_NREG       = 5;

   // ***********************************************************
   // writable bit masks (unused bits read zero)
   // ***********************************************************
   localparam logic [7:0] PPS_MASK_RETRY  = 8'h03;
   localparam logic [7:0] PPS_MASK_GEN    = 8'h57;
   localparam logic [7:0] PPS_MASK_INUV   = 8'h0F;
   localparam logic [7:0] PPS_MASK_CABLE  = 8'hF7;
   localparam logic [7:0] PPS_MASK_WINDOW = 8'h77;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [7:0] PPS_RST_RETRY  = 8'h03;
   localparam logic [7:0] PPS_RST_GEN    = 8'h04;
   localparam logic [7:0] PPS_RST_INUV   = 8'h00;
   localparam logic [7:0] PPS_RST_CABLE  = 8'h63;
   localparam logic [7:0] PPS_RST_WINDOW = 8'h33;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int PPS_POS_RETRY    = 0;
   localparam int PPS_POS_FINE     = 6;
   localparam int PPS_POS_OUTSIDE  = 4;
   localparam int PPS_POS_CLREG    = 2;
   localparam int PPS_POS_CHG      = 0;
   localparam int PPS_POS_INLOW    = 0;
   localparam int PPS_POS_CABLE_OC = 4;
   localparam int PPS_POS_CABLE_UV = 0;
   localparam int PPS_POS_HIGH     = 4;
   localparam int PPS_POS_LOW      = 0;

   // ***********************************************************
   // field limits
   // ***********************************************************
   localparam logic [3:0] PPS_INLOW_MAX    = 4'hA;
   localparam logic [3:0] PPS_CABLE_OC_MAX = 4'h9;

   // ***********************************************************
   // timing: retry delays at 20 MHz
   // ***********************************************************
   localparam longint PPS_CLK_HZ      = 20_000_000;
   localparam longint PPS_RETRY0_MS   = 2000;
   localparam longint PPS_RETRY1_MS   = 1000;
   localparam longint PPS_RETRY2_MS   = 500;
   localparam longint PPS_RETRY3_MS   = 16;
   localparam longint PPS_RETRY0_CYC  = PPS_RETRY0_MS * PPS_CLK_HZ / 1000;
   localparam longint PPS_RETRY1_CYC  = PPS_RETRY1_MS * PPS_CLK_HZ / 1000;
   localparam longint PPS_RETRY2_CYC  = PPS_RETRY2_MS * PPS_CLK_HZ / 1000;
   localparam longint PPS_RETRY3_CYC  = PPS_RETRY3_MS * PPS_CLK_HZ / 1000;

   // ***********************************************************
   // enumerations
   // ***********************************************************
   typedef enum logic [1:0] {
      PPS_CHG_PASS = 2'h0,
      PPS_CHG_CDP  = 2'h1,
      PPS_CHG_D24  = 2'h2,
      PPS_CHG_D10  = 2'h3
   } pps_chg_t;

   // ***********************************************************
   // carriers
   // ***********************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pps_req_t;

   typedef struct packed {
      logic [1:0] fault_retry_delay;
      logic       fine_voltage_step;
      logic       outside_supply_choice;
      logic       current_limit_regulation_on;
      pps_chg_t   charge_detect_select;
      logic [3:0] input_low_level;
      logic [3:0] cable_supply_overcurrent_low;
      logic [2:0] cable_supply_low_level;
      logic [2:0] output_high_margin;
      logic [2:0] output_low_margin;
   } pps_cfg_t;
endpackage : pps_pkg
`default_nettype wire

//--- design/pps_setup_regs.sv
// Purpose: five configuration registers and the logic they steer
// Assumes: register port synchronous to i_sys_clk, one access per cycle
// Notes:   retry, current-limit and bias decisions made here for analog
`default_nettype none

module pps_setup_regs
   import pps_pkg::*;
(
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_b,
   // register port
   input  wire pps_req_t   i_req,
   output logic [7:0]      o_rdata,
   output logic            o_rvalid,
   // analog and fault inputs
   input  wire logic       i_bias_valid,
   input  wire logic       i_over_current,
   input  wire logic       i_fault,
   // configuration and decisions
   output pps_cfg_t        o_cfg,
   output logic            o_step_mv10,
   output logic            o_int_bias_on,
   output logic            o_current_limit,
   output logic            o_mode_change_flag,
   output logic            o_cv_limit_fault,
   output logic            o_retry_busy
);

   // ***********************************************************
   // register storage
   // ***********************************************************
   logic [7:0] regs [PPS_NREG];
   logic [PPS_NREG-1:0] hit;
   logic       bias_reset;

   // per-register constants, constant so the reset branch stays constant
   localparam logic [7:0] OFF_TAB  [PPS_NREG] = '{PPS_OFF_RETRY, PPS_OFF_GEN, PPS_OFF_INUV,
                                                  PPS_OFF_CABLE, PPS_OFF_WINDOW};
   localparam logic [7:0] MASK_TAB [PPS_NREG] = '{PPS_MASK_RETRY, PPS_MASK_GEN, PPS_MASK_INUV,
                                                  PPS_MASK_CABLE, PPS_MASK_WINDOW};
   localparam logic [7:0] RST_TAB  [PPS_NREG] = '{PPS_RST_RETRY, PPS_RST_GEN, PPS_RST_INUV,
                                                  PPS_RST_CABLE, PPS_RST_WINDOW};

   // register file, reset by bias failure too
   genvar g;
   generate
      for (g = 0; g < PPS_NREG; g++) begin : g_reg
         assign hit[g] = (i_req.addr == OFF_TAB[g]);
         always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               regs[g] <= RST_TAB[g];
            end else if (bias_reset) begin
               regs[g] <= RST_TAB[g];
            end else if (i_req.wr && hit[g]) begin
               regs[g] <= i_req.wdata & MASK_TAB[g];
            end
         end
      end
   endgenerate

   // ***********************************************************
   // field decode
   // ***********************************************************
   logic [7:0] r_ret, r_gen, r_inuv, r_cab, r_win;
   assign r_ret  = regs[0];
   assign r_gen  = regs[1];
   assign r_inuv = regs[2];
   assign r_cab  = regs[3];
   assign r_win  = regs[4];

   always_comb begin
      o_cfg.fault_retry_delay            = r_ret[PPS_POS_RETRY +: 2];
      o_cfg.fine_voltage_step            = r_gen[PPS_POS_FINE];
      o_cfg.outside_supply_choice        = r_gen[PPS_POS_OUTSIDE];
      o_cfg.current_limit_regulation_on  = r_gen[PPS_POS_CLREG];
      o_cfg.charge_detect_select         = pps_chg_t'(r_gen[PPS_POS_CHG +: 2]);
      o_cfg.input_low_level              = r_inuv[PPS_POS_INLOW +: 4];
      o_cfg.cable_supply_overcurrent_low = r_cab[PPS_POS_CABLE_OC +: 4];
      o_cfg.cable_supply_low_level       = r_cab[PPS_POS_CABLE_UV +: 3];
      o_cfg.output_high_margin           = r_win[PPS_POS_HIGH +: 3];
      o_cfg.output_low_margin            = r_win[PPS_POS_LOW +: 3];
   end

   assign o_step_mv10 = o_cfg.fine_voltage_step;
   assign o_int_bias_on = !o_cfg.outside_supply_choice;
   // outside supply selected or being selected but absent
   assign bias_reset = !i_bias_valid && (o_cfg.outside_supply_choice
                       || (i_req.wr && hit[1] && i_req.wdata[PPS_POS_OUTSIDE]));

   // ***********************************************************
   // read port
   // ***********************************************************
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_req.rd;
         unique case (1'b1)
            hit[0]:  o_rdata <= r_ret;
            hit[1]:  o_rdata <= r_gen;
            hit[2]:  o_rdata <= r_inuv;
            hit[3]:  o_rdata <= r_cab;
            hit[4]:  o_rdata <= r_win;
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // ***********************************************************
   // current limit and mode change
   // ***********************************************************
   logic cl_prev;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_current_limit <= 1'b0;
      end else begin
         o_current_limit <= o_cfg.current_limit_regulation_on && i_over_current;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cl_prev            <= 1'b0;
         o_mode_change_flag <= 1'b0;
      end else begin
         cl_prev <= o_current_limit;
         if (o_cfg.current_limit_regulation_on && (cl_prev != o_current_limit)) begin
            o_mode_change_flag <= 1'b1;
         end else if (!o_cfg.current_limit_regulation_on) begin
            o_mode_change_flag <= 1'b0;
         end
      end
   end

   // regulation off: overcurrent is a fault
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cv_limit_fault <= 1'b0;
      end else if (!o_cfg.current_limit_regulation_on && i_over_current) begin
         o_cv_limit_fault <= 1'b1;
      end else if (o_cfg.current_limit_regulation_on) begin
         o_cv_limit_fault <= 1'b0;
      end
   end

   // ***********************************************************
   // retry timer
   // ***********************************************************
   logic [31:0] retry_cnt;
   logic [31:0] retry_load;
   always_comb begin
      case (o_cfg.fault_retry_delay)
         2'h0:    retry_load = 32'(PPS_RETRY0_CYC);
         2'h1:    retry_load = 32'(PPS_RETRY1_CYC);
         2'h2:    retry_load = 32'(PPS_RETRY2_CYC);
         default: retry_load = 32'(PPS_RETRY3_CYC);
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         retry_cnt <= 32'h0000_0000;
      end else if (i_fault || o_cv_limit_fault) begin
         retry_cnt <= retry_load;
      end else if (retry_cnt != 32'h0000_0000) begin
         retry_cnt <= retry_cnt - 32'h0000_0001;
      end
   end
   assign o_retry_busy = (retry_cnt != 32'h0000_0000);

endmodule // pps_setup_regs
`default_nettype wire

//--- dv/pps_setup_regs_assertions.sv
// Purpose: port assertions for the setup register block
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every instance of the design top
`default_nettype none
module pps_setup_regs_assertions
   import pps_pkg::*;
(
   // clock and reset
   input wire logic       i_sys_clk,
   input wire logic       i_rst_b,
   // watched ports
   input wire pps_req_t   i_req,
   input wire logic [7:0] o_rdata,
   input wire logic       o_rvalid,
   input wire logic       i_bias_valid,
   input wire logic       i_over_current,
   input wire logic       i_fault,
   input wire pps_cfg_t   o_cfg,
   input wire logic       o_step_mv10,
   input wire logic       o_int_bias_on,
   input wire logic       o_current_limit,
   input wire logic       o_mode_change_flag,
   input wire logic       o_cv_limit_fault,
   input wire logic       o_retry_busy
);
   // ********************
   // checks
   // ********************
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   chk_read_answer: assert property (i_req.rd |=> o_rvalid)
      else $error("read not answered");
   chk_reset_fields: assert property ($rose(i_rst_b) |-> o_cfg.fault_retry_delay == 2'h3
      && o_cfg.current_limit_regulation_on && o_cfg.cable_supply_low_level == 3'h3)
      else $error("fields not at reset value");
   chk_fine_step: assert property (o_step_mv10 == o_cfg.fine_voltage_step)
      else $error("step output differs from field");
   chk_bias_source: assert property (o_int_bias_on != o_cfg.outside_supply_choice)
      else $error("internal bias wrong");
   chk_bias_guard: assert property (i_req.wr && i_req.addr == PPS_OFF_GEN
      && i_req.wdata[4] && !i_bias_valid |=> !o_cfg.outside_supply_choice
      && o_cfg.output_low_margin == 3'h3) else $error("unguarded bias select");
   chk_limit_enter: assert property ((o_cfg.current_limit_regulation_on
      && i_over_current) [*2] |-> ##[0:2] o_current_limit) else $error("no current limit");
   chk_limit_off: assert property (!o_cfg.current_limit_regulation_on [*2]
      |-> !o_current_limit) else $error("current limit while disabled");
   chk_inlow_write: assert property (i_req.wr && i_req.addr == PPS_OFF_INUV
      |=> o_cfg.input_low_level == $past(i_req.wdata[3:0])) else $error("write lost");
   chk_unused_zero: assert property (o_rvalid && $past(i_req.addr) == PPS_OFF_CABLE
      |-> !o_rdata[3]) else $error("unused bit reads one");
   chk_retry_start: assert property ($rose(i_fault) |-> ##[0:2] o_retry_busy)
      else $error("retry wait not started");
   chk_flag_clear: assert property (!o_cfg.current_limit_regulation_on [*3]
      |-> !o_mode_change_flag) else $error("mode flag kept");
   chk_cv_fault_set: assert property (!o_cfg.current_limit_regulation_on
      && i_over_current |=> o_cv_limit_fault) else $error("overcurrent fault missing");
   cov_limit: cover property (o_current_limit);
   cov_retry: cover property (o_retry_busy);
   cov_read: cover property (o_rvalid);
endmodule // pps_setup_regs_assertions

bind pps_setup_regs pps_setup_regs_assertions u_chk (.i_sys_clk, .i_rst_b, .i_req, .o_rdata,
   .o_rvalid, .i_bias_valid, .i_over_current, .i_fault, .o_cfg, .o_step_mv10,
   .o_int_bias_on, .o_current_limit, .o_mode_change_flag, .o_cv_limit_fault, .o_retry_busy);
`default_nettype wire

//--- dv/pps_host_model.sv
// Purpose: host model issuing register accesses
// Assumes: requests launched just after rising edges
// Notes:   owns the outside bias supply
`default_nettype none
module pps_host_model
   import pps_pkg::*;
(
   // clock, register port and outside bias supply
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output pps_req_t        o_req,
   output logic            o_bias_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // accesses
   // ********************
   // idle port, no bias
   initial begin
      o_req = '0;
      o_bias_valid = 1'b0;
   end
   task automatic set_bias(input logic v);
      @(posedge i_clk);
      o_bias_valid <= v;
   endtask
   // millivolts to fine target code, integer only
   function automatic logic [15:0] fine_code(input int mv);
      return 16'(mv / 10 - ((304 * mv) / 100000 - 10));
   endfunction
   // one-cycle write
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk);
      o_req <= '0;
   endtask
   // read, data taken in answer cycle
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_clk);
      o_req <= '0;
      #1 d = i_rdata;
   endtask
endmodule // pps_host_model
`default_nettype wire

//--- dv/pps_setup_regs_tb.sv
// Purpose: self-checking bench for the setup registers
// Assumes: 20 MHz clock, reset held six cycles
// Notes:   the retry wait is checked only for its start
`default_nettype none
module pps_setup_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pps_pkg::*;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pps_row_t;
   // ********************
   // stimulus tables
   // ********************
   // reserved threshold codes never written
   localparam pps_row_t ROWS [16] = '{'{8'h85, 8'h00, 8'h00}, '{8'h85, 8'h01, 8'h01},
      '{8'h85, 8'h02, 8'h02}, '{8'h85, 8'hFF, 8'h03}, '{8'h86, 8'h44, 8'h44},
      '{8'h86, 8'h05, 8'h05}, '{8'h86, 8'h06, 8'h06}, '{8'h86, 8'h07, 8'h07},
      '{8'h87, 8'hFA, 8'h0A}, '{8'h87, 8'h00, 8'h00}, '{8'h88, 8'h9F, 8'h97},
      '{8'h88, 8'h08, 8'h00}, '{8'h89, 8'hF0, 8'h70}, '{8'h89, 8'h8F, 8'h07},
      '{8'h8A, 8'hFF, 8'h00}, '{8'h84, 8'h55, 8'h00}};
   localparam pps_row_t RSTS [5] = '{'{8'h85, 8'h00, 8'h03}, '{8'h86, 8'h00, 8'h04},
      '{8'h87, 8'h00, 8'h00}, '{8'h88, 8'h00, 8'h63}, '{8'h89, 8'h00, 8'h33}};
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       over_current = 1'b0;
   logic       fault = 1'b0;
   logic       bias_valid;
   pps_req_t   req;
   pps_cfg_t   cfg;
   logic [7:0] rdata;
   logic [7:0] got;
   logic       rvalid, step_mv10, int_bias_on, cur_limit, mode_flag, cv_fault, retry_busy;
   int         fail_count = 0;
   int         n_checks = 0;
   // 50 ns clock
   always #25 clk = ~clk;
   pps_setup_regs u_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req), .o_rdata(rdata),
      .o_rvalid(rvalid), .i_bias_valid(bias_valid), .i_over_current(over_current),
      .i_fault(fault), .o_cfg(cfg), .o_step_mv10(step_mv10), .o_int_bias_on(int_bias_on),
      .o_current_limit(cur_limit), .o_mode_change_flag(mode_flag),
      .o_cv_limit_fault(cv_fault), .o_retry_busy(retry_busy));
   pps_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_req(req), .o_bias_valid(bias_valid));
   // ********************
   // helpers
   // ********************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
      u_host.read_reg(a, got);
      check(name, got, e);
      check("rvalid", 8'(rvalid), 8'h01);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic end_sim;
      if (fail_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      foreach (ROWS[i]) begin
         u_host.write_reg(ROWS[i].a, ROWS[i].d);
         rd_chk("readback", ROWS[i].a, ROWS[i].e);
      end
      u_host.write_reg(8'h86, 8'h44);
      wait_cyc(1);
      check("step", 8'(step_mv10), 8'h01);
      check("int_bias", 8'(int_bias_on), 8'h01);
      u_host.write_reg(8'h86, 8'h14);
      rd_chk("guard_window", 8'h89, 8'h33);
      rd_chk("guard_gen", 8'h86, 8'h04);
      u_host.set_bias(1'b1);
      u_host.write_reg(8'h86, 8'h14);
      wait_cyc(1);
      check("ext_bias", 8'(int_bias_on), 8'h00);
      @(posedge clk);
      over_current <= 1'b1;
      wait_cyc(4);
      check("limit_on", 8'(cur_limit), 8'h01);
      check("mode_flag_set", 8'(mode_flag), 8'h01);
      u_host.write_reg(8'h86, 8'h10);
      wait_cyc(4);
      check("limit_off", 8'(cur_limit), 8'h00);
      check("cv_fault", 8'(cv_fault), 8'h01);
      check("mode_flag", 8'(mode_flag), 8'h00);
      @(posedge clk);
      over_current <= 1'b0;
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      foreach (RSTS[i]) rd_chk("reset", RSTS[i].a, RSTS[i].e);
      check("cv_fault_rst", 8'(cv_fault), 8'h00);
      check("int_bias_rst", 8'(int_bias_on), 8'h01);
      check("retry_idle", 8'(retry_busy), 8'h00);
      @(posedge clk);
      fault <= 1'b1;
      @(posedge clk);
      fault <= 1'b0;
      wait_cyc(2);
      check("retry_busy", 8'(retry_busy), 8'h01);
      end_sim();
   end
endmodule // pps_setup_regs_tb
`default_nettype wire
